// *** hw/rsc_consts.svh ***
// Register offsets, field positions, reset values and timing counts of the reset-source block
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
`define RSC_OFF_THRESH      12'h000
`define RSC_OFF_FLAGS       12'h004
`define RSC_OFF_STATUS      12'h008
`define RSC_OFF_MASK        12'h00c
`define RSC_OFF_CTRL        12'h010
`define RSC_OFF_EVENTS      12'h014
`define RSC_CODE_2V10       8'h55
`define RSC_CODE_2V55       8'h33
`define RSC_CODE_3V15       8'h99
`define RSC_CODE_3V80       8'haa
`define RSC_FLAG_LVR_BIT    2
`define RSC_FLAG_BAD_BIT    1
`define RSC_FLAG_WMASK      8'h89
`define RSC_EVT_BITS        4
`define RSC_DELAY_SLOW      2'h3
`define RSC_STACK_TOP       4'hf
`endif

// *** hw/rsc_pkg.sv ***
// Types shared by the reset-source block
package rsc_pkg;
   typedef enum logic [1:0] {RSC_NONE, RSC_LVR, RSC_BAD} rsc_cause_t;
   // Outgoing reset controls towards the core
   typedef struct packed {
      logic       mcu_reset;       // Full reset of the core
      logic       pc_clear;        // Program counter to zero
      logic       sp_clear;        // Stack pointer to zero
      logic       sp_top;          // Stack pointer to top
      logic       irq_disable;     // All interrupts disabled
      logic       wdt_clear;       // Watchdog and time base cleared
      logic       timers_off;      // Timer modules off
      logic       ports_input;     // All port pins to input
   } rsc_ctl_t;
endpackage

// *** hw/rsc_top.sv ***
// Reset-source control: threshold select, reset cause flags, watchdog status flags
`timescale 1ns/10ps
`include "rsc_consts.svh"

module rsc_top
(
   // Bus clock and reset (reset acts as power-on)
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite write address
   input  wire logic [11:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Asynchronous event inputs
   input  wire logic                low_speed_osc_clock,
   input  wire logic                low_voltage_detect,
   input  wire logic                external_reset_pin,
   input  wire logic                watchdog_timeout,
   input  wire logic                power_down_mode,
   // Reset controls and interrupt
   output rsc_pkg::rsc_ctl_t        reset_ctl,
   output logic                     irq
);
   import rsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers: two flops each, first flop read only by the second
   localparam int NSYNC = 5;
   // Reset to each pin's idle level: the reset pin idles high, so no false event
   localparam logic [NSYNC-1:0] SYNC_IDLE = 5'b00100;
   logic [NSYNC-1:0] sync_a;                     // First stage
   logic [NSYNC-1:0] sync_b;                     // Second stage, safe to use
   logic [NSYNC-1:0] raw_in;                     // Asynchronous inputs gathered

   assign raw_in = {power_down_mode, watchdog_timeout, external_reset_pin,
                    low_voltage_detect, low_speed_osc_clock};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         // Synchroniser for one input bit
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               sync_a[gi] <= SYNC_IDLE[gi];
               sync_b[gi] <= SYNC_IDLE[gi];
            end
            else
            begin
               sync_a[gi] <= raw_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   logic slow_q;                                 // Delayed slow clock level
   logic slow_tick;                              // One slow-clock rising edge
   logic lvd_s;                                  // Low voltage, synchronised
   logic pin_s;                                  // Reset pin, active low level
   logic wdt_s;                                  // Watchdog timeout level
   logic wdt_q;                                  // Previous watchdog level
   logic pd_s;                                   // In power-down mode

   assign lvd_s = sync_b[1];
   assign pin_s = sync_b[2];
   assign wdt_s = sync_b[3];
   assign pd_s  = sync_b[4];
   assign slow_tick = sync_b[0] & ~slow_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] threshold_select_code;            // Low voltage threshold select
   logic       low_voltage_reset_flag;           // Cause: low voltage
   logic       bad_threshold_code_flag;          // Cause: undefined code
   logic [7:0] flags_other;                      // Bits 7, 3, 0 held as plain storage
   logic       watchdog_timeout_flag;            // Watchdog timed out
   logic       power_down_flag;                  // Timeout happened in sleep mode
   logic       sleep_mode;                       // Software says core sleeps/idles
   logic [`RSC_EVT_BITS-1:0] evt_status;         // Sticky event bits
   logic [`RSC_EVT_BITS-1:0] evt_mask;           // Interrupt enables

   logic code_valid;
   assign code_valid = (threshold_select_code == `RSC_CODE_2V10) ||
                       (threshold_select_code == `RSC_CODE_2V55) ||
                       (threshold_select_code == `RSC_CODE_3V15) ||
                       (threshold_select_code == `RSC_CODE_3V80);

   ////////////////////////////////////////////////////////////////////////////////
   // Slow-clock delay counter for pending reset requests
   rsc_cause_t  pend;                            // Request waiting for its delay
   logic [1:0]  slow_cnt;                        // Slow edges seen since request
   logic        fire_lvr;                        // Low voltage reset now
   logic        fire_bad;                        // Undefined code reset now
   logic        lvr_req;

   // Disabled in power-down, so a sagging supply there never resets
   assign lvr_req = lvd_s & ~pd_s;

   // Request latched, then counted on slow clock edges; a fixed count of 3 edges
   // lands in the 2..3 cycle window whatever the phase; a supply that recovers first drops it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         slow_q   <= 1'b0;
         pend     <= RSC_NONE;
         slow_cnt <= 2'h0;
      end
      else
      begin
         slow_q <= sync_b[0];
         if (fire_lvr || fire_bad || (pend == RSC_LVR && !lvr_req))
         begin
            pend     <= RSC_NONE;
            slow_cnt <= 2'h0;
         end
         else if (pend == RSC_NONE)
         begin
            // Bad code has priority: it also forces the code back
            if (!code_valid)
               pend <= RSC_BAD;
            else if (lvr_req)
               pend <= RSC_LVR;
         end
         else if (slow_tick)
            slow_cnt <= slow_cnt + 2'h1;
      end
   end

   assign fire_lvr = (pend == RSC_LVR) && slow_tick &&
                     (slow_cnt == `RSC_DELAY_SLOW - 2'h1);
   assign fire_bad = (pend == RSC_BAD) && slow_tick &&
                     (slow_cnt == `RSC_DELAY_SLOW - 2'h1);

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path
   logic        aw_got;
   logic        w_got;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;

   assign do_write = aw_got && w_got && !s_axi_bvalid;

   // Capture address and data in either order, answer once both held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_addr       <= 12'h000;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end
      else
      begin
         s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_got && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got  <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got  <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Offsets above the control register answer with a slave error
            s_axi_bresp  <= (aw_addr > `RSC_OFF_CTRL) ? 2'h2 : 2'h0;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   logic wr_thr;
   logic wr_flg;
   assign wr_thr = do_write && aw_addr == `RSC_OFF_THRESH && w_strb[0];
   assign wr_flg = do_write && aw_addr == `RSC_OFF_FLAGS && w_strb[0];

   ////////////////////////////////////////////////////////////////////////////////
   // Threshold code: kept through a low voltage reset, restored by a bad-code reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         threshold_select_code <= `RSC_CODE_2V10;
      else if (fire_bad)
         threshold_select_code <= `RSC_CODE_2V10;
      else if (wr_thr)
         threshold_select_code <= w_data[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reset cause flags; hardware set wins over a software clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         low_voltage_reset_flag  <= 1'b0;
         bad_threshold_code_flag <= 1'b0;
         flags_other             <= 8'h00;
      end
      else
      begin
         if (wr_flg)
         begin
            low_voltage_reset_flag  <= w_data[`RSC_FLAG_LVR_BIT];
            bad_threshold_code_flag <= w_data[`RSC_FLAG_BAD_BIT];
            flags_other             <= w_data[7:0] & `RSC_FLAG_WMASK;
         end
         if (fire_lvr)
            low_voltage_reset_flag <= 1'b1;
         if (fire_bad)
            bad_threshold_code_flag <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog timeout and power-down flags
   logic wdt_evt;
   logic pin_evt;
   logic wr_ctl;
   assign wdt_evt = wdt_s & ~wdt_q;
   assign pin_evt = ~pin_s;
   assign wr_ctl  = do_write && aw_addr == `RSC_OFF_CTRL && w_strb[0];

   // Pin and low voltage resets leave both flags alone
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wdt_q                 <= 1'b0;
         watchdog_timeout_flag <= 1'b0;
         power_down_flag       <= 1'b0;
         sleep_mode            <= 1'b0;
      end
      else
      begin
         wdt_q <= wdt_s;
         if (wr_ctl)
            sleep_mode <= w_data[0];
         if (wdt_evt)
         begin
            watchdog_timeout_flag <= 1'b1;
            if (sleep_mode)
            begin
               power_down_flag <= 1'b1;
               sleep_mode      <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reset controls towards the core, one cycle pulses except the pin reset, held while the pin is low, and power-on levels
   logic por_hold;                               // First cycle after release
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // Power-on state: everything cleared and parked
         por_hold  <= 1'b1;
         reset_ctl <= '{mcu_reset: 1'b1, pc_clear: 1'b1, sp_clear: 1'b0,
                        sp_top: 1'b1, irq_disable: 1'b1, wdt_clear: 1'b1,
                        timers_off: 1'b1, ports_input: 1'b1};
      end
      else
      begin
         por_hold <= 1'b0;
         // Full resets: low voltage, bad code, pin, or watchdog while running
         reset_ctl.mcu_reset   <= fire_lvr | fire_bad | pin_evt |
                                  (wdt_evt & ~sleep_mode);
         reset_ctl.pc_clear    <= fire_lvr | fire_bad | pin_evt | wdt_evt;
         reset_ctl.sp_clear    <= wdt_evt & sleep_mode;
         reset_ctl.sp_top      <= por_hold;
         reset_ctl.irq_disable <= por_hold;
         // Watchdog clears once, then free to count
         reset_ctl.wdt_clear   <= por_hold;
         reset_ctl.timers_off  <= por_hold;
         reset_ctl.ports_input <= por_hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt events: lvr, bad code, watchdog, pin
   logic [`RSC_EVT_BITS-1:0] evt_now;
   logic wr_sts;
   logic wr_msk;
   assign evt_now = {pin_evt, wdt_evt, fire_bad, fire_lvr};
   assign wr_sts  = do_write && aw_addr == `RSC_OFF_STATUS && w_strb[0];
   assign wr_msk  = do_write && aw_addr == `RSC_OFF_MASK && w_strb[0];

   // Write one clears; a new event in the same cycle stays set
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         evt_status <= '0;
         evt_mask   <= '0;
         irq        <= 1'b0;
      end
      else
      begin
         evt_status <= (evt_status & ~(wr_sts ? w_data[`RSC_EVT_BITS-1:0] : '0))
                       | evt_now;
         if (wr_msk)
            evt_mask <= w_data[`RSC_EVT_BITS-1:0];
         irq <= |(evt_status & evt_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path, one register cycle after address accepted
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (s_axi_araddr)
         `RSC_OFF_THRESH: rd_mux[7:0] = threshold_select_code;
         `RSC_OFF_FLAGS:  rd_mux[7:0] = flags_other |
                                        {5'h00, low_voltage_reset_flag,
                                         bad_threshold_code_flag, 1'b0};
         `RSC_OFF_STATUS: rd_mux[`RSC_EVT_BITS-1:0] = evt_status;
         `RSC_OFF_MASK:   rd_mux[`RSC_EVT_BITS-1:0] = evt_mask;
         `RSC_OFF_CTRL:   rd_mux[3:0] = {code_valid, power_down_flag,
                                         watchdog_timeout_flag, sleep_mode};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // Address taken and data returned in the same edge pair
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (s_axi_araddr > `RSC_OFF_CTRL) ? 2'h2 : 2'h0;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// *** test/rsc_top_properties.sv ***
// Checker of the reset-source block, bound to its top module
`timescale 1ns/10ps
module rsc_chk
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Bus handshakes
   input  wire logic              s_axi_awvalid,
   input  wire logic              s_axi_awready,
   input  wire logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   input  wire logic              s_axi_arready,
   input  wire logic [31:0]       s_axi_rdata,
   input  wire logic [1:0]        s_axi_rresp,
   input  wire logic              s_axi_rvalid,
   // Reset controls
   input  wire rsc_pkg::rsc_ctl_t reset_ctl
);
   import rsc_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   logic [11:0] rd_addr;   // Address of the read in flight

   // Remember the read address, since rdata comes a cycle after the handshake
   always_ff @(posedge aclk)
      if (s_axi_arvalid && s_axi_arready)
         rd_addr <= s_axi_araddr;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   a_por_state: assert property (
      $rose(aresetn) |-> reset_ctl.pc_clear && reset_ctl.irq_disable && reset_ctl.wdt_clear
         && reset_ctl.timers_off && reset_ctl.ports_input && reset_ctl.sp_top
         && !reset_ctl.sp_clear)
      else $error("power-on controls not all set at release");
   a_por_hold: assert property (
      $rose(aresetn) |=> reset_ctl.sp_top && reset_ctl.ports_input)
      else $error("power-on controls dropped too early");
   a_sleep_wake: assert property (
      reset_ctl.sp_clear |-> reset_ctl.pc_clear && !reset_ctl.mcu_reset)
      else $error("sleep wake must clear pc and sp without full reset");
   a_full_reset: assert property (
      reset_ctl.mcu_reset |-> reset_ctl.pc_clear)
      else $error("full reset without pc clear");
   a_wr_answer: assert property (
      s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   a_b_done: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held after handshake");
   a_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rd_unmapped: assert property (
      s_axi_rvalid && rd_addr > 12'h010 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_flag_gap: assert property (
      s_axi_rvalid && rd_addr == 12'h004 |-> s_axi_rdata[6:4] == 3'h0)
      else $error("unimplemented flag bits read nonzero");
endmodule
bind rsc_top rsc_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .reset_ctl(reset_ctl));

// *** test/tb.sv ***
// Self-checking testbench of the reset-source block
`timescale 1ns/10ps
module tb;
   import rsc_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   logic        aclk = 1'b0, aresetn = 1'b0;                 // Clock and reset
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;              // Bus addresses
   logic [31:0] wdata = 32'h0, rdata;                        // Bus data
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp;
   logic        slow = 1'b0, lvd = 1'b0, pin_n = 1'b1;       // Event inputs
   logic        wdt = 1'b0, pdm = 1'b0;
   logic [3:0]  sdiv = 4'h0;                                 // Slow clock divider
   rsc_ctl_t    ctl;                                         // Reset controls
   logic [31:0] seed = 32'h7570;                             // Random state
   logic [31:0] d;
   logic [1:0]  r;
   logic [7:0]  codes [4] = '{8'h55, 8'h33, 8'h99, 8'haa};   // Accepted codes
   int          n_mismatch = 0, checks_done = 0, n_rst = 0, n_spc = 0, b, c;

   rsc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .low_speed_osc_clock(slow), .low_voltage_detect(lvd),
      .external_reset_pin(pin_n), .watchdog_timeout(wdt), .power_down_mode(pdm),
      .reset_ctl(ctl), .irq(irq));

   always #4 aclk = ~aclk;

   // Slow clock at one sixteenth of the bus clock; count reset pulses
   always @(posedge aclk)
   begin
      sdiv  <= sdiv + 4'h1;
      slow  <= sdiv[3];
      n_rst <= n_rst + int'(ctl.mcu_reset);
      n_spc <= n_spc + int'(ctl.sp_clear);
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask

   task automatic close_out();
      $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Write one word; the request is held until each channel is taken
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
      int i;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (i = 0; i < 100 && !bvalid; i++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      if (i == 100)
      begin
         n_mismatch++;
         close_out();
      end
      rs = bresp;
      bready <= 1'b0;
   endtask

   // Read one word; arvalid held until taken, rready until data seen
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
      int i;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (i = 0; i < 100 && !rvalid; i++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end
      if (i == 100)
      begin
         n_mismatch++;
         close_out();
      end
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
      logic [31:0] v;
      logic [1:0]  rs;
      rd(a, v, rs);
      chk(nm, e, v);
   endtask

   // Wait for a reset pulse (or sleep wake) counter to move past its base
   task automatic wait_ev(input int base, input bit sp, output int cyc);
      for (cyc = 0; cyc < 300 && (sp ? n_spc : n_rst) == base; cyc++)
         @(posedge aclk);
      if (cyc == 300)
      begin
         chk("event wait bound", 32'h0, 32'h1);
         close_out();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rdchk(12'h000, 32'h55, "threshold after power-on");
      rdchk(12'h004, 32'h0, "flags after power-on");
      rdchk(12'h010, 32'h8, "control after power-on");
      foreach (codes[k])
      begin
         wr(12'h000, {24'h0, codes[k]}, r);
         rdchk(12'h000, {24'h0, codes[k]}, "accepted code");
      end
      d = xs();
      wr(12'h004, d, r);
      rdchk(12'h004, d & 32'h8f, "flag write");
      wr(12'h004, 32'h0, r);
      // Low voltage at the selected threshold: full reset, code kept
      wr(12'h000, 32'h99, r);
      b = n_rst;
      lvd <= 1'b1;
      wait_ev(b, 1'b0, c);
      lvd <= 1'b0;
      chk("low-voltage delay in window", 32'h1, 32'(c >= 36 && c <= 54));
      rdchk(12'h000, 32'h99, "code kept over low-voltage reset");
      rdchk(12'h004, 32'h4, "low-voltage flag");
      rdchk(12'h010, 32'h8, "status flags after low-voltage reset");
      wr(12'h004, 32'h0, r);
      rdchk(12'h004, 32'h0, "flag cleared by software");
      // Power-down blocks the low-voltage reset
      pdm <= 1'b1;
      repeat (2) @(posedge aclk);
      b = n_rst;
      lvd <= 1'b1;
      repeat (100) @(posedge aclk);
      chk("resets during power-down", b, n_rst);
      lvd <= 1'b0;
      repeat (4) @(posedge aclk);
      pdm <= 1'b0;
      // Random undefined code: reset after the slow delay, code restored
      do
         d = xs() & 32'h0000_00ff;
      while (d[7:0] inside {8'h55, 8'h33, 8'h99, 8'haa});
      b = n_rst;
      wr(12'h000, d, r);
      wait_ev(b, 1'b0, c);
      chk("bad-code delay in window", 32'h1, 32'(c >= 33 && c <= 52));
      rdchk(12'h000, 32'h55, "code restored");
      rdchk(12'h004, 32'h2, "bad-code flag");
      // Watchdog time-out while running
      b = n_spc;
      wdt <= 1'b1;
      wait_ev(n_rst, 1'b0, c);
      wdt <= 1'b0;
      chk("sleep wake in normal time-out", b, n_spc);
      rdchk(12'h010, 32'ha, "flags after normal time-out");
      // Reset pin held low for a few cycles
      b = n_rst;
      pin_n <= 1'b0;
      repeat (3) @(posedge aclk);
      pin_n <= 1'b1;
      wait_ev(b, 1'b0, c);
      rdchk(12'h010, 32'ha, "flags after pin reset");
      // Watchdog time-out during sleep
      wr(12'h010, 32'h1, r);
      repeat (2) @(posedge aclk);
      b = n_rst;
      wdt <= 1'b1;
      wait_ev(n_spc, 1'b1, c);
      wdt <= 1'b0;
      chk("full reset in sleep time-out", b, n_rst);
      rdchk(12'h010, 32'he, "flags after sleep time-out");
      // Interrupt: all four events latched, then mask and clear
      rdchk(12'h008, 32'hf, "event status");
      wr(12'h00c, 32'h0, r);
      repeat (3) @(posedge aclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(12'h00c, 32'h2, r);
      repeat (3) @(posedge aclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(12'h008, 32'hf, r);
      repeat (3) @(posedge aclk);
      chk("irq after clear", 32'h0, {31'h0, irq});
      rdchk(12'h008, 32'h0, "status cleared");
      // Unmapped address
      wr(12'h020, 32'hff, r);
      chk("unmapped write response", 32'h2, {30'h0, r});
      rd(12'h020, d, r);
      chk("unmapped read response", 32'h2, {30'h0, r});
      close_out();
   end
endmodule
